// ==== common/rcb_pkg.sv ====
package rcb_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned TICK_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned LOCKOUT_MS = 500;
	localparam int AW = 4;
	localparam int DW = 16;
	localparam int TW = 16;
	localparam int NCYC = 8;
	localparam int NBLK = 4;

	typedef logic [AW-1:0] rcb_addr_t;
	typedef logic [DW-1:0] rcb_data_t;
	typedef logic [TW-1:0] rcb_time_t;

	localparam rcb_addr_t ADDR_CTRL = 4'h0;
	localparam rcb_addr_t ADDR_SHOTS = 4'h1;
	localparam rcb_addr_t ADDR_DEAD1P = 4'h2;
	localparam rcb_addr_t ADDR_DEAD3P = 4'h3;
	localparam rcb_addr_t ADDR_DEADPH1 = 4'h4;
	localparam rcb_addr_t ADDR_DEADPH2 = 4'h5;
	localparam rcb_addr_t ADDR_DEADPH3 = 4'h6;
	localparam rcb_addr_t ADDR_RECLAIM = 4'h7;
	localparam rcb_addr_t ADDR_MCBLOCK = 4'h8;
	localparam rcb_addr_t ADDR_CBSUPV = 4'h9;
	localparam rcb_addr_t ADDR_STATUS = 4'ha;

	localparam int CTRL_RDY_FIRST = 0;
	localparam int CTRL_RDY_EACH = 1;
	localparam int CTRL_ADT = 2;
	localparam int CTRL_PICKUP = 3;
	localparam int CTRL_ALLOW3P = 4;
	localparam int CTRL_FORCED3P = 5;
	localparam int CTRL_INDIV = 6;

	localparam rcb_data_t CTRL_RST = 16'h0013;
	localparam logic [3:0] SHOTS_RST = 4'h1;
	localparam rcb_time_t DEAD1P_RST = 16'h03e8;
	localparam rcb_time_t DEAD3P_RST = 16'h01f4;
	localparam rcb_time_t RECLAIM_RST = 16'h0bb8;
	localparam rcb_time_t MCBLOCK_RST = 16'h0bb8;
	localparam rcb_time_t CBSUPV_RST = 16'h0bb8;
	localparam rcb_time_t LOCKOUT_TIME = rcb_time_t'(LOCKOUT_MS);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_TRIPPED = 3'b001,
		ST_DEAD = 3'b010,
		ST_RECLAIM = 3'b011,
		ST_LOCKOUT = 3'b100
	} rcb_state_t;
endpackage

// ==== common/rcb_tmr_if.sv ====
`timescale 1ns/10ps
interface rcb_tmr_if;
	logic start;
	rcb_pkg::rcb_time_t load;
	logic busy;
	logic done;
	modport ctl(output start, output load, input busy, input done);
	modport tmr(input start, input load, output busy, output done);
endinterface

// ==== rtl/rcb_tick.sv ====
`timescale 1ns/10ps
module rcb_tick #(
	parameter int unsigned TICK_CYC = rcb_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rstB,
	output logic tick
);
	import rcb_pkg::*;
	typedef struct packed {
		logic [31:0] cnt;
		logic tick;
	} rcb_tick_st_t;
	rcb_tick_st_t q, d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.cnt >= TICK_CYC - 1) begin
			d.cnt = 32'h0;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rstB) begin
		if (!rstB) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign tick = q.tick;
endmodule // rcb_tick

// ==== rtl/rcb_timer.sv ====
`timescale 1ns/10ps
module rcb_timer (
	input wire logic clk,
	input wire logic rstB,
	input wire logic tick,
	rcb_tmr_if.tmr tif
);
	import rcb_pkg::*;
	typedef struct packed {
		rcb_time_t cnt;
		logic busy;
		logic done;
	} rcb_tmr_st_t;
	rcb_tmr_st_t q, d;

	// A zero load expires at once; a start always restarts
	always_comb begin
		d = q;
		d.done = 1'b0;
		if (tif.start) begin
			d.cnt = tif.load;
			d.busy = (tif.load != '0);
			d.done = (tif.load == '0);
		end else if (q.busy && tick) begin
			d.cnt = q.cnt - 16'h1;
			if (q.cnt == 16'h1) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstB) begin
		if (!rstB) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign tif.busy = q.busy;
	assign tif.done = q.done;
endmodule // rcb_timer

// ==== rtl/rcb_top.sv ====
// Overview of operation
// - Global block refuses start, else lock-out
// - Blocked cycles are skipped when selecting
// - Running cycle blocked aborts, no close
// - Close starts reclaim; adaptive zero disables
// - Reclaim expiry returns to idle
// - Reclaim trip: next cycle or unsuccessful
// - Lock-out holds 0.5 s, then quiescent
// - Manual close blocks; trips then final
// - First trip needs breaker ready
// - Optional readiness check before later shots
// - Ready supervision expiry gives lock-out
// - Series contacts decode open count
// - No start unless breaker was closed
// - Dead time starts on trip drop or open
// - Three poles open after one-pole trip
// - Two poles open before dead time: final, couple three-pole
// - Pole opening in dead time goes three-pole
// - Three-pole cycle: dead, close, reclaim
// - Pickup mode picks dead time by fault
// - Unsuccessful: final trip, then lock-out
// - At most eight chained attempts
// - Only first trip initiates the sequence
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module rcb_top #(
	parameter int unsigned TICK_CYC = rcb_pkg::TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire rcb_pkg::rcb_addr_t regAddr,
	input wire rcb_pkg::rcb_data_t regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output rcb_pkg::rcb_data_t regRdata,
	input wire logic tripIn,
	input wire logic tripSinglePole,
	input wire logic [1:0] pickupPhases,
	input wire logic blockAllIn,
	input wire logic [rcb_pkg::NBLK-1:0] cycleBlockIn,
	input wire logic manualCloseIn,
	input wire logic breakerReadyInput,
	input wire logic poleAAuxContact,
	input wire logic poleBAuxContact,
	input wire logic poleCAuxContact,
	input wire logic allPolesOpenInput,
	input wire logic allPolesClosedInput,
	output logic closeCmd,
	output logic trip3pCmd,
	output logic finalTrip,
	output logic arRunning,
	output logic arLockout
);
	import rcb_pkg::*;

	typedef struct packed {
		rcb_state_t st;
		rcb_data_t ctrl;
		logic [3:0] shots;
		rcb_time_t dead1p;
		rcb_time_t dead3p;
		rcb_time_t deadPh1;
		rcb_time_t deadPh2;
		rcb_time_t deadPh3;
		rcb_time_t reclaim;
		rcb_time_t mcTime;
		rcb_time_t cbTime;
		rcb_data_t rdData;
		logic [2:0] shot;
		logic onePole;
		logic laterShot;
		logic deadOver;
		logic tripPrev;
		logic readyPrev;
		logic wasClosed;
		logic seqStart;
		rcb_time_t seqLoad;
		logic mcStart;
		logic cbStart;
		logic close;
		logic trip3p;
		logic fin;
		logic running;
		logic lock;
	} rcb_top_st_t;

	rcb_top_st_t q, d;
	logic [1:0] rstSync_q;
	logic rstB;
	logic tick;
	logic [NCYC-1:0] cycOk;
	logic [1:0] openCnt;
	logic allClosed;
	logic twoOpenIndiv;
	logic tripRise;
	logic goLock;
	logic [3:0] nextCyc;
	rcb_data_t rdMux;

	rcb_tmr_if seqTmr();
	rcb_tmr_if mcTmr();
	rcb_tmr_if cbTmr();

	// Assert at once, release after two clean edges
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync_q <= 2'h0;
		end else begin
			rstSync_q <= {rstSync_q[0], 1'b1};
		end
	end
	assign rstB = rstSync_q[1];

	rcb_tick #(.TICK_CYC(TICK_CYC)) uTick (
		.clk(mclk),
		.rstB(rstB),
		.tick(tick)
	);
	rcb_timer uSeqTmr (.clk(mclk), .rstB(rstB), .tick(tick), .tif(seqTmr.tmr));
	rcb_timer uMcTmr (.clk(mclk), .rstB(rstB), .tick(tick), .tif(mcTmr.tmr));
	rcb_timer uCbTmr (.clk(mclk), .rstB(rstB), .tick(tick), .tif(cbTmr.tmr));

	assign seqTmr.start = q.seqStart;
	assign seqTmr.load = q.seqLoad;
	assign mcTmr.start = q.mcStart;
	assign mcTmr.load = q.mcTime;
	assign cbTmr.start = q.cbStart;
	assign cbTmr.load = q.cbTime;

	// Cycles five to eight share the fourth cycle's block input
	for (genvar g = 0; g < NCYC; g++) begin : gCycOk
		assign cycOk[g] = ~cycleBlockIn[(g < NBLK) ? g : NBLK - 1];
	end

	// Series contacts cannot tell one open pole from two
	always_comb begin
		if (q.ctrl[CTRL_INDIV]) begin
			openCnt = 2'({1'b0, ~poleAAuxContact} + {1'b0, ~poleBAuxContact}
				+ {1'b0, ~poleCAuxContact});
			allClosed = poleAAuxContact & poleBAuxContact & poleCAuxContact;
		end else if (allPolesOpenInput) begin
			openCnt = 2'h3;
			allClosed = 1'b0;
		end else if (allPolesClosedInput) begin
			openCnt = 2'h0;
			allClosed = 1'b1;
		end else begin
			openCnt = 2'h1;
			allClosed = 1'b0;
		end
		twoOpenIndiv = q.ctrl[CTRL_INDIV] && (openCnt == 2'h2);
	end

	function automatic logic [3:0] firstCyc(input logic [NCYC-1:0] ok,
		input logic [3:0] from, input logic [3:0] lim);
		logic [3:0] r;
		r = 4'h8;
		for (int i = NCYC - 1; i >= 0; i--) begin
			if (ok[i] && (4'(i) >= from) && (4'(i) < lim)) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	function automatic rcb_time_t deadSel(input rcb_top_st_t s, input logic onePole,
		input logic [1:0] ph);
		rcb_time_t t;
		t = s.dead3p;
		if (onePole) begin
			t = s.dead1p;
		end else if (s.ctrl[CTRL_PICKUP]) begin
			t = (ph == 2'h1) ? s.deadPh1 : (ph == 2'h2) ? s.deadPh2 : s.deadPh3;
		end
		return t;
	endfunction

	always_comb begin
		unique case (regAddr)
			ADDR_CTRL: rdMux = q.ctrl;
			ADDR_SHOTS: rdMux = {12'h000, q.shots};
			ADDR_DEAD1P: rdMux = q.dead1p;
			ADDR_DEAD3P: rdMux = q.dead3p;
			ADDR_DEADPH1: rdMux = q.deadPh1;
			ADDR_DEADPH2: rdMux = q.deadPh2;
			ADDR_DEADPH3: rdMux = q.deadPh3;
			ADDR_RECLAIM: rdMux = q.reclaim;
			ADDR_MCBLOCK: rdMux = q.mcTime;
			ADDR_CBSUPV: rdMux = q.cbTime;
			ADDR_STATUS: rdMux = {5'h00, mcTmr.busy, cbTmr.busy, seqTmr.busy,
				q.onePole, q.laterShot, q.shot, q.st};
			default: rdMux = 16'h0000;
		endcase
	end

	always_comb begin
		d = q;
		goLock = 1'b0;
		nextCyc = 4'h8;
		tripRise = tripIn & ~q.tripPrev;
		d.tripPrev = tripIn;
		d.readyPrev = breakerReadyInput;
		d.seqStart = 1'b0;
		d.mcStart = 1'b0;
		d.cbStart = 1'b0;
		d.close = 1'b0;
		d.trip3p = 1'b0;
		d.fin = 1'b0;
		d.rdData = regRd ? rdMux : 16'h0000;
		if (regWr) begin
			unique case (regAddr)
				ADDR_CTRL: d.ctrl = regWdata;
				ADDR_SHOTS: d.shots = (regWdata[3:0] > 4'h8) ? 4'h8 : regWdata[3:0];
				ADDR_DEAD1P: d.dead1p = regWdata;
				ADDR_DEAD3P: d.dead3p = regWdata;
				ADDR_DEADPH1: d.deadPh1 = regWdata;
				ADDR_DEADPH2: d.deadPh2 = regWdata;
				ADDR_DEADPH3: d.deadPh3 = regWdata;
				ADDR_RECLAIM: d.reclaim = regWdata;
				ADDR_MCBLOCK: d.mcTime = regWdata;
				ADDR_CBSUPV: d.cbTime = regWdata;
				default: ;
			endcase
		end
		if (manualCloseIn) begin
			d.mcStart = 1'b1;
		end
		if (!tripIn) begin
			d.wasClosed = allClosed;
		end
		// Also arm when readiness was already missing as the sequence started
		if (q.running && !breakerReadyInput
			&& (q.readyPrev || !(cbTmr.busy || q.cbStart))) begin
			d.cbStart = 1'b1;
		end
		unique case (q.st)
			ST_IDLE: begin
				nextCyc = firstCyc(cycOk, 4'h0, q.shots);
				if (tripRise) begin
					if (mcTmr.busy || mcTmr.start) begin
						d.fin = 1'b1;
						goLock = 1'b1;
					end else if (!blockAllIn && q.wasClosed && nextCyc != 4'h8
						&& (breakerReadyInput || !q.ctrl[CTRL_RDY_FIRST])) begin
						d.shot = nextCyc[2:0];
						d.onePole = tripSinglePole;
						d.laterShot = 1'b0;
						d.deadOver = 1'b0;
						d.st = ST_TRIPPED;
					end
				end
			end
			ST_TRIPPED: begin
				if (blockAllIn || !cycOk[q.shot]) begin
					goLock = 1'b1;
				end else if (!tripIn || openCnt != 2'h0) begin
					if (q.onePole && twoOpenIndiv) begin
						d.trip3p = 1'b1;
						d.fin = 1'b1;
						goLock = 1'b1;
					end else if (q.onePole && openCnt == 2'h3) begin
						if (q.ctrl[CTRL_ALLOW3P] && !q.ctrl[CTRL_PICKUP]) begin
							d.onePole = 1'b0;
							d.seqStart = 1'b1;
							d.seqLoad = q.dead3p;
							d.st = ST_DEAD;
						end else begin
							d.fin = 1'b1;
							goLock = 1'b1;
						end
					end else begin
						d.seqStart = 1'b1;
						d.seqLoad = deadSel(q, q.onePole, pickupPhases);
						d.st = ST_DEAD;
					end
				end
			end
			ST_DEAD: begin
				if (blockAllIn || !cycOk[q.shot]) begin
					goLock = 1'b1;
				end else if (q.onePole && openCnt > 2'h1) begin
					if (twoOpenIndiv && q.ctrl[CTRL_FORCED3P]) begin
						d.trip3p = 1'b1;
					end
					if (q.ctrl[CTRL_ALLOW3P]) begin
						d.onePole = 1'b0;
						d.seqStart = 1'b1;
						d.seqLoad = deadSel(q, 1'b0, pickupPhases);
					end else begin
						d.fin = 1'b1;
						goLock = 1'b1;
					end
				end else if (seqTmr.done || q.deadOver) begin
					// Dead time stretches while a later shot waits for readiness
					if (q.ctrl[CTRL_RDY_EACH] && q.laterShot && !breakerReadyInput) begin
						d.deadOver = 1'b1;
						if (cbTmr.done) begin
							goLock = 1'b1;
						end
					end else begin
						d.deadOver = 1'b0;
						d.close = 1'b1;
						d.laterShot = 1'b1;
						d.seqStart = 1'b1;
						d.seqLoad = q.reclaim;
						d.st = ST_RECLAIM;
						if (q.ctrl[CTRL_ADT] && q.reclaim == 16'h0000) begin
							d.seqStart = 1'b0;
							d.st = ST_IDLE;
						end
					end
				end
			end
			ST_RECLAIM: begin
				nextCyc = firstCyc(cycOk, {1'b0, q.shot} + 4'h1, q.shots);
				if (blockAllIn) begin
					goLock = 1'b1;
				end else if (tripRise) begin
					if (nextCyc == 4'h8) begin
						d.trip3p = 1'b1;
						d.fin = 1'b1;
						goLock = 1'b1;
					end else begin
						d.shot = nextCyc[2:0];
						d.onePole = tripSinglePole;
						d.st = ST_TRIPPED;
					end
				end else if (seqTmr.done) begin
					d.st = ST_IDLE;
				end
			end
			ST_LOCKOUT: begin
				if (seqTmr.done) begin
					d.st = ST_IDLE;
				end
			end
			default: d.st = ST_IDLE;
		endcase
		if (q.running && cbTmr.done && !breakerReadyInput) begin
			goLock = 1'b1;
		end
		if (goLock) begin
			d.st = ST_LOCKOUT;
			d.close = 1'b0;
			d.seqStart = 1'b1;
			d.seqLoad = LOCKOUT_TIME;
			d.deadOver = 1'b0;
		end
		d.running = (d.st == ST_TRIPPED) || (d.st == ST_DEAD) || (d.st == ST_RECLAIM);
		d.lock = (d.st == ST_LOCKOUT);
	end

	always_ff @(posedge mclk or negedge rstB) begin
		if (!rstB) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.ctrl <= CTRL_RST;
			q.shots <= SHOTS_RST;
			q.dead1p <= DEAD1P_RST;
			q.dead3p <= DEAD3P_RST;
			q.deadPh1 <= DEAD3P_RST;
			q.deadPh2 <= DEAD3P_RST;
			q.deadPh3 <= DEAD3P_RST;
			q.reclaim <= RECLAIM_RST;
			q.mcTime <= MCBLOCK_RST;
			q.cbTime <= CBSUPV_RST;
		end else begin
			q <= d;
		end
	end

	assign regRdata = q.rdData;
	assign closeCmd = q.close;
	assign trip3pCmd = q.trip3p;
	assign finalTrip = q.fin;
	assign arRunning = q.running;
	assign arLockout = q.lock;
endmodule // rcb_top

// ==== testbench/rcb_assertions.sv ====
`timescale 1ns/10ps
module rcb_assertions #(
	parameter int unsigned TICK_CYC = 4
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic tripIn,
	input wire logic blockAllIn,
	input wire logic breakerReadyInput,
	input wire logic allPolesClosedInput,
	input wire logic closeCmd,
	input wire logic finalTrip,
	input wire logic arRunning,
	input wire logic arLockout
);
	// Tick phase is free running, so allow one tick either way
	localparam int LO_MIN = 499 * TICK_CYC;
	localparam int LO_MAX = 501 * TICK_CYC + 4;
	logic [15:0] loCnt_q;
	logic quiet;
	assign quiet = !arRunning && !arLockout;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			loCnt_q <= 16'h0000;
		end else begin
			loCnt_q <= arLockout ? loCnt_q + 16'h0001 : 16'h0000;
		end
	end
	close_pulse_a: assert property (closeCmd |=> !closeCmd)
		else $error("close command wider than one cycle");
	close_seq_a: assert property (closeCmd |-> $past(arRunning) && !arLockout)
		else $error("close command outside a running sequence");
	final_lock_a: assert property (finalTrip |-> ##[0:1] arLockout)
		else $error("final trip without lock-out");
	lock_excl_a: assert property (arLockout |-> !arRunning && !closeCmd)
		else $error("activity during lock-out");
	glob_block_a: assert property ($rose(tripIn) && blockAllIn && quiet |=> !arRunning[*2])
		else $error("start despite global block");
	ready_first_a: assert property ($rose(tripIn) && !breakerReadyInput && quiet |=> !arRunning[*2])
		else $error("start with breaker not ready");
	closed_first_a: assert property ($rose(tripIn) && !allPolesClosedInput && quiet |=> !arRunning[*2])
		else $error("start with breaker not closed");
	start_cause_a: assert property ($rose(arRunning) |-> $past(tripIn) || $past(tripIn, 2))
		else $error("sequence started without a trip");
	lock_max_a: assert property (arLockout |-> loCnt_q <= LO_MAX)
		else $error("lock-out held too long");
	lock_min_a: assert property ($fell(arLockout) |-> loCnt_q >= LO_MIN)
		else $error("lock-out released too early");
	close_c: cover property (closeCmd);
	final_c: cover property (finalTrip);
	unlock_c: cover property ($fell(arLockout));
endmodule // rcb_assertions

bind rcb_top rcb_assertions #(.TICK_CYC(TICK_CYC)) chkU (
	.mclk(mclk), .rst_b(rst_b), .tripIn(tripIn), .blockAllIn(blockAllIn),
	.breakerReadyInput(breakerReadyInput), .allPolesClosedInput(allPolesClosedInput),
	.closeCmd(closeCmd), .finalTrip(finalTrip), .arRunning(arRunning), .arLockout(arLockout)
);

// ==== testbench/rcb_breaker_model.sv ====
`timescale 1ns/10ps
module rcb_breaker_model #(
	parameter int OPEN_DLY = 3,
	parameter int CLOSE_DLY = 2
) (
	input wire logic clk,
	input wire logic tripIn,
	input wire logic closeCmd,
	input wire logic manualCloseIn,
	input wire logic holdOpen,
	input wire logic rdyEn,
	output logic breakerReadyInput,
	output logic poleAAuxContact,
	output logic poleBAuxContact,
	output logic poleCAuxContact,
	output logic allPolesOpenInput,
	output logic allPolesClosedInput
);
	logic closed_q = 1'b1;
	logic tgt_q = 1'b1;
	logic tripPrev_q = 1'b0;
	logic [2:0] trav_q = 3'h0;
	// Mid-travel one pole lags, so neither series input is active
	assign allPolesClosedInput = closed_q && trav_q == 3'h0;
	assign allPolesOpenInput = !closed_q && trav_q == 3'h0;
	assign poleAAuxContact = allPolesClosedInput;
	assign poleBAuxContact = allPolesClosedInput;
	assign poleCAuxContact = allPolesClosedInput;
	// Readiness drops only when the bench asks for it
	assign breakerReadyInput = rdyEn;
	always @(posedge clk) begin
		tripPrev_q <= tripIn;
		if (holdOpen) begin
			closed_q <= 1'b0;
			trav_q <= 3'h0;
		end else if (trav_q != 3'h0) begin
			trav_q <= trav_q - 3'h1;
			if (trav_q == 3'h1) closed_q <= tgt_q;
		end else if (tripIn && !tripPrev_q && closed_q) begin
			trav_q <= 3'(OPEN_DLY);
			tgt_q <= 1'b0;
		end else if ((closeCmd || manualCloseIn) && !closed_q) begin
			trav_q <= 3'(CLOSE_DLY);
			tgt_q <= 1'b1;
		end
	end
endmodule // rcb_breaker_model

// ==== testbench/rcb_top_tb.sv ====
`timescale 1ns/10ps
module rcb_top_tb;
	import rcb_pkg::*;
	localparam int TC = 4;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	rcb_addr_t regAddr = '0;
	rcb_data_t regWdata = '0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic tripIn = 1'b0;
	logic blockAllIn = 1'b0;
	logic [NBLK-1:0] cycleBlockIn = '0;
	logic manualCloseIn = 1'b0;
	logic holdOpen = 1'b0;
	logic rdyEn = 1'b1;
	logic onePoleTrip = 1'b0;
	logic [1:0] phases = 2'h2;
	rcb_data_t regRdata;
	logic rdy, pa, pb, pc, aOpen, aClosed;
	logic closeCmd, trip3pCmd, finalTrip, arRunning, arLockout;
	int numErrors = 0;
	int checks = 0;
	int now = 0;
	int cyc = 0;
	int nClose, nFinal, n3p, closeAt;
	always #25 mclk = ~mclk;
	rcb_top #(.TICK_CYC(TC)) dut_u (
		.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .tripIn(tripIn), .tripSinglePole(onePoleTrip),
		.pickupPhases(phases), .blockAllIn(blockAllIn), .cycleBlockIn(cycleBlockIn),
		.manualCloseIn(manualCloseIn), .breakerReadyInput(rdy), .poleAAuxContact(pa),
		.poleBAuxContact(pb), .poleCAuxContact(pc), .allPolesOpenInput(aOpen),
		.allPolesClosedInput(aClosed), .closeCmd(closeCmd), .trip3pCmd(trip3pCmd),
		.finalTrip(finalTrip), .arRunning(arRunning), .arLockout(arLockout)
	);
	rcb_breaker_model cbU (
		.clk(mclk), .tripIn(tripIn), .closeCmd(closeCmd), .manualCloseIn(manualCloseIn),
		.holdOpen(holdOpen), .rdyEn(rdyEn), .breakerReadyInput(rdy), .poleAAuxContact(pa),
		.poleBAuxContact(pb), .poleCAuxContact(pc), .allPolesOpenInput(aOpen),
		.allPolesClosedInput(aClosed)
	);
	task automatic printVerdict();
		$display("checks %0d mismatches %0d", checks, numErrors);
		if (numErrors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			numErrors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Samples the cycle that ends at each edge, before flops update
	task automatic run(input int n);
		repeat (n) begin
			@(posedge mclk);
			now++;
			if (closeCmd === 1'b1) begin
				nClose++;
				closeAt = now;
			end
			if (finalTrip === 1'b1) nFinal++;
			if (trip3pCmd === 1'b1) n3p++;
		end
	endtask
	task automatic wr(input rcb_addr_t a, input rcb_data_t d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		run(1);
		regWr <= 1'b0;
		run(1);
	endtask
	task automatic rd(input rcb_addr_t a, input rcb_data_t e);
		regAddr <= a;
		regRd <= 1'b1;
		run(1);
		regRd <= 1'b0;
		run(1);
		chk("regRdata", e, regRdata);
	endtask
	task automatic trip();
		tripIn <= 1'b1;
		run(2);
		tripIn <= 1'b0;
	endtask
	// Manual close recloses the breaker; waiting outlasts its block time
	task automatic prep();
		manualCloseIn <= 1'b1;
		run(1);
		manualCloseIn <= 1'b0;
		run(60);
		nClose = 0;
		nFinal = 0;
		n3p = 0;
	endtask
	task automatic idle();
		int k;
		k = 0;
		while (k < 2300 && (arLockout !== 1'b0 || arRunning !== 1'b0)) begin
			run(1);
			k++;
		end
		chk("quiet", 16'h0001, 16'(k < 2300));
	endtask
	task automatic s_regs();
		rd(ADDR_CTRL, CTRL_RST);
		rd(ADDR_SHOTS, 16'(SHOTS_RST));
		rd(ADDR_RECLAIM, RECLAIM_RST);
		wr(4'hf, 16'h1234);
		rd(4'hf, 16'h0000);
		wr(ADDR_SHOTS, 16'h0009);
		rd(ADDR_SHOTS, 16'h0008);
		wr(ADDR_DEAD3P, 16'h0005);
		wr(ADDR_RECLAIM, 16'h000a);
		wr(ADDR_MCBLOCK, 16'h000a);
		wr(ADDR_DEADPH2, 16'h0008);
		rd(ADDR_DEAD3P, 16'h0005);
	endtask
	task automatic s_success();
		int t0;
		prep();
		trip();
		t0 = now;
		run(40);
		chk("closes", 16'h0001, 16'(nClose));
		chk("dead", 16'h0001, 16'(closeAt - t0 >= 16 && closeAt - t0 <= 30));
		chk("reclaim", 16'h0001, 16'(arRunning));
		run(50);
		chk("back idle", 16'h0000, 16'({arRunning, arLockout}));
	endtask
	task automatic s_shots(input int shots);
		wr(ADDR_SHOTS, 16'(shots));
		prep();
		repeat (shots) begin
			trip();
			run(38);
		end
		chk("closes", 16'(shots), 16'(nClose));
		trip();
		run(4);
		chk("final", 16'h0001, 16'(nFinal));
		chk("coupled", 16'h0001, 16'(n3p));
		chk("lockout", 16'h0001, 16'(arLockout));
		run(1500);
		chk("held", 16'h0001, 16'(arLockout));
		idle();
	endtask
	task automatic s_block(input logic [4:0] b);
		wr(ADDR_SHOTS, 16'h0001);
		prep();
		{blockAllIn, cycleBlockIn} <= b;
		trip();
		run(8);
		chk("refused", 16'h0000, 16'(arRunning));
		{blockAllIn, cycleBlockIn} <= 5'h00;
		prep();
		trip();
		run(5);
		{blockAllIn, cycleBlockIn} <= b;
		run(40);
		chk("aborted", 16'h0000, 16'(nClose));
		chk("blocked", 16'h0001, 16'(arLockout));
		{blockAllIn, cycleBlockIn} <= 5'h00;
		idle();
	endtask
	task automatic s_refuse(input logic r, input logic o);
		prep();
		rdyEn <= r;
		holdOpen <= o;
		run(4);
		trip();
		run(8);
		chk("no start", 16'h0000, 16'({arRunning, arLockout}));
		rdyEn <= 1'b1;
		holdOpen <= 1'b0;
	endtask
	task automatic s_manual();
		prep();
		manualCloseIn <= 1'b1;
		run(1);
		manualCloseIn <= 1'b0;
		run(4);
		trip();
		run(4);
		chk("mc final", 16'h0001, 16'(nFinal));
		chk("mc lock", 16'h0001, 16'(arLockout));
		idle();
	endtask
	// Zero reclaim in adaptive mode: idle in the very cycle of the close
	task automatic s_adt();
		int k;
		k = 0;
		wr(ADDR_CTRL, 16'h0017);
		wr(ADDR_RECLAIM, 16'h0000);
		prep();
		trip();
		while (k < 40 && closeCmd !== 1'b1) begin
			run(1);
			k++;
		end
		chk("adt idle", 16'h0000, 16'(arRunning));
		run(30);
		trip();
		run(30);
		chk("adt closes", 16'h0002, 16'(nClose));
		chk("adt new", 16'h0000, 16'(nFinal));
		wr(ADDR_CTRL, CTRL_RST);
		wr(ADDR_RECLAIM, 16'h000a);
	endtask
	// A zero upper bound means the trip must end final with no close
	task automatic s_mode(input rcb_data_t ctrl, input logic p1, input int lo, input int hi);
		int t0;
		wr(ADDR_CTRL, ctrl);
		onePoleTrip <= p1;
		prep();
		trip();
		t0 = now;
		run(50);
		chk("mode close", 16'(hi > 0), 16'(nClose));
		chk("mode dead", 16'(hi > 0), 16'(closeAt - t0 >= lo && closeAt - t0 <= hi));
		chk("mode final", 16'(hi == 0), 16'(nFinal));
		onePoleTrip <= 1'b0;
		idle();
		wr(ADDR_CTRL, CTRL_RST);
	endtask
	task automatic s_ready();
		wr(ADDR_SHOTS, 16'h0002);
		wr(ADDR_CBSUPV, 16'h0014);
		prep();
		trip();
		run(38);
		rdyEn <= 1'b0;
		trip();
		run(60);
		chk("held off", 16'h0001, 16'(nClose));
		rdyEn <= 1'b1;
		run(10);
		chk("resumed", 16'h0002, 16'(nClose));
		prep();
		trip();
		run(38);
		rdyEn <= 1'b0;
		trip();
		run(100);
		chk("supervised", 16'h0001, 16'(arLockout));
		chk("no close", 16'h0001, 16'(nClose));
		rdyEn <= 1'b1;
		idle();
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			numErrors++;
			printVerdict();
		end
	end
	initial begin
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		run(4);
		s_regs();
		s_success();
		s_shots(1);
		s_shots(8);
		s_block(5'h10);
		s_block(5'h01);
		s_refuse(1'b0, 1'b0);
		s_refuse(1'b1, 1'b1);
		s_manual();
		s_adt();
		s_mode(CTRL_RST, 1'b1, 16, 30);
		s_mode(16'h0003, 1'b1, 0, 0);
		s_mode(16'h001b, 1'b0, 30, 40);
		s_ready();
		printVerdict();
	end
endmodule // rcb_top_tb
